// *** logic/cbms_boot_mode_select.sv ***
// Purpose: boot mode choice and auto-calibration checks
// Assumes: stored counters are stable at reset release
// Notes:   all inputs come from logic on ref_clk
// Overview of operation
// - Analogue type, counter pair 0/255: angle cal
// - CAN type, CAN pair 0/255: angle cal
// - CAN, no CAN cal, joystick pair: joystick cal
// - No sensor, joystick pair: joystick cal
// - Analogue/CAN, nothing above, spool pair: spool cal
// - Otherwise boot into normal operation
// - Angle cal captures three points, scales permille
// - Joystick cal captures three points, scales permille
// - Spool dead-band from timed left-right sweep
// - Neutral upper limit mV, 0..5000, 4500
// - Minimum spread mV, 0..2500, default 0
// - Neutral lower limit mV, 0..5000, 500
// - Dead-band edges within min 0, max 300
// - Spool start within timeout 1..60, 20
// - Spool sweep starts at set-point 50..300, 125
// - Interface type: 0 analogue, 1 CAN, 2 none
// - Neutral outside limits reports calibration error
`include "cbms_defs.svh"
`default_nettype none
module cbms_boot_mode_select
    import cbms_pkg::*;
#(
    parameter int TICK_CYCLES = `CBMS_SECOND_NS / `CBMS_CLK_NS
) (
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire logic [7:0]         sensor_interface_type,
    input  wire logic [7:0]         analog_angle_cal_counter,
    input  wire logic [7:0]         analog_angle_cal_counter_inv,
    input  wire logic [7:0]         can_angle_cal_counter,
    input  wire logic [7:0]         can_angle_cal_counter_inv,
    input  wire logic [7:0]         joystick_cal_counter,
    input  wire logic [7:0]         joystick_cal_counter_inv,
    input  wire logic [7:0]         spool_cal_counter,
    input  wire logic [7:0]         spool_cal_counter_inv,
    input  wire logic               paramWrEn,
    input  wire logic [2:0]         paramSel,
    input  wire logic [15:0]        paramWrData,
    output logic                    paramWrRefused,
    output logic [15:0]             paramRdData,
    input  wire logic [15:0]        sensorMv,
    input  wire logic               captureLeft,
    input  wire logic               captureRight,
    input  wire logic               captureNeutral,
    input  wire logic               motionStopped,
    input  wire logic               startRequest,
    input  wire logic               sweepBegin,
    input  wire logic               sweepEnd,
    input  wire logic signed [15:0] measuredEdge,
    output cbms_mode_t              bootMode,
    output logic                    bootDone,
    output logic                    calDone,
    output logic                    errNeutral,
    output logic                    errSpread,
    output logic signed [15:0]      positionPermille,
    output cbms_spool_t             spoolState,
    output logic [15:0]             spoolSetpoint,
    output logic [31:0]             sweepCycles,
    output logic signed [15:0]      deadbandEdge,
    output logic                    errDeadband,
    output logic                    errTimeout
);
    if (TICK_CYCLES < 1) $error("TICK_CYCLES must be at least 1");

    // ==========================================================
    // Parameter store
    logic [15:0] neutral_capture_upper_mv;
    logic [15:0] capture_min_spread_mv;
    logic [15:0] neutral_capture_lower_mv;
    logic [15:0] deadband_edge_upper;
    logic [15:0] deadband_edge_lower;
    logic [7:0]  spool_cal_start_timeout;
    logic [15:0] spool_cal_initial_setpoint;
    logic        inRange;

    always_comb begin
        unique case (paramSel)
            `CBMS_SEL_NEU_UP:  inRange = paramWrData <= `CBMS_MAX_MV;
            `CBMS_SEL_SPREAD:  inRange = paramWrData <= `CBMS_MAX_SPREAD;
            `CBMS_SEL_NEU_LO:  inRange = paramWrData <= `CBMS_MAX_MV;
            `CBMS_SEL_DB_UP,
            `CBMS_SEL_DB_LO:   inRange = paramWrData <= `CBMS_MAX_DB;
            `CBMS_SEL_TIMEOUT: inRange = paramWrData[15:8] == 8'h00
                                  && paramWrData[7:0] >= `CBMS_MIN_TIMEOUT
                                  && paramWrData[7:0] <= `CBMS_MAX_TIMEOUT;
            `CBMS_SEL_SETPT:   inRange = paramWrData >= `CBMS_MIN_SETPT
                                  && paramWrData <= `CBMS_MAX_SETPT;
            default:           inRange = 1'b0;
        endcase
    end

    assign paramWrRefused = paramWrEn && !inRange;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            neutral_capture_upper_mv   <= `CBMS_RST_NEU_UP;
            capture_min_spread_mv      <= `CBMS_RST_SPREAD;
            neutral_capture_lower_mv   <= `CBMS_RST_NEU_LO;
            deadband_edge_upper        <= `CBMS_RST_DB_UP;
            deadband_edge_lower        <= `CBMS_RST_DB_LO;
            spool_cal_start_timeout    <= `CBMS_RST_TIMEOUT;
            spool_cal_initial_setpoint <= `CBMS_RST_SETPT;
        end else if (paramWrEn && inRange) begin
            unique case (paramSel)
                `CBMS_SEL_NEU_UP:  neutral_capture_upper_mv   <= paramWrData;
                `CBMS_SEL_SPREAD:  capture_min_spread_mv      <= paramWrData;
                `CBMS_SEL_NEU_LO:  neutral_capture_lower_mv   <= paramWrData;
                `CBMS_SEL_DB_UP:   deadband_edge_upper        <= paramWrData;
                `CBMS_SEL_DB_LO:   deadband_edge_lower        <= paramWrData;
                `CBMS_SEL_TIMEOUT: spool_cal_start_timeout    <= paramWrData[7:0];
                default:           spool_cal_initial_setpoint <= paramWrData;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            paramRdData <= 16'h0000;
        end else begin
            unique case (paramSel)
                `CBMS_SEL_NEU_UP:  paramRdData <= neutral_capture_upper_mv;
                `CBMS_SEL_SPREAD:  paramRdData <= capture_min_spread_mv;
                `CBMS_SEL_NEU_LO:  paramRdData <= neutral_capture_lower_mv;
                `CBMS_SEL_DB_UP:   paramRdData <= deadband_edge_upper;
                `CBMS_SEL_DB_LO:   paramRdData <= deadband_edge_lower;
                `CBMS_SEL_TIMEOUT: paramRdData <= {8'h00, spool_cal_start_timeout};
                `CBMS_SEL_SETPT:   paramRdData <= spool_cal_initial_setpoint;
                default:           paramRdData <= 16'h0000;
            endcase
        end
    end

    // ==========================================================
    // Boot decision
    logic       isAnalog, isCan, isNone;
    logic       condA1, condB1, condA2, condB2, cond3;
    cbms_mode_t next_bootMode;

    assign isAnalog = sensor_interface_type == `CBMS_IF_ANALOG;
    assign isCan    = sensor_interface_type == `CBMS_IF_CAN;
    assign isNone   = sensor_interface_type == `CBMS_IF_NONE;
    assign condA1 = isAnalog && analog_angle_cal_counter == `CBMS_CNT_ZERO
                    && analog_angle_cal_counter_inv == `CBMS_CNT_INV;
    assign condB1 = isCan && can_angle_cal_counter == `CBMS_CNT_ZERO
                    && can_angle_cal_counter_inv == `CBMS_CNT_INV;
    assign condA2 = isCan && !condB1 && joystick_cal_counter == `CBMS_CNT_ZERO
                    && joystick_cal_counter_inv == `CBMS_CNT_INV;
    assign condB2 = isNone && joystick_cal_counter == `CBMS_CNT_ZERO
                    && joystick_cal_counter_inv == `CBMS_CNT_INV;
    assign cond3  = (isAnalog || isCan) && !condA1 && !condB1 && !condA2
                    && spool_cal_counter == `CBMS_CNT_ZERO
                    && spool_cal_counter_inv == `CBMS_CNT_INV;

    always_comb begin
        if (condA1 || condB1)      next_bootMode = MODE_ANGLE_CAL;
        else if (condA2 || condB2) next_bootMode = MODE_JOY_CAL;
        else if (cond3)            next_bootMode = MODE_SPOOL_CAL;
        else                       next_bootMode = MODE_NORMAL;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bootMode <= MODE_NORMAL;
            bootDone <= 1'b0;
        end else if (!bootDone) begin
            bootMode <= next_bootMode;
            bootDone <= 1'b1;
        end
    end

    // ==========================================================
    // Three-point analogue capture and scaling
    logic        capEnable;
    logic [15:0] capL, capR, capN;
    logic [2:0]  capHave;
    logic signed [31:0] diffS, spanR, spanL, spanUse, scaled;
    logic        spreadUp, spreadDown;

    assign capEnable = bootDone
        && (bootMode == MODE_ANGLE_CAL || bootMode == MODE_JOY_CAL);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            capL    <= 16'h0000;
            capR    <= 16'h0000;
            capN    <= 16'h0000;
            capHave <= 3'h0;
        end else if (capEnable) begin
            if (captureLeft) begin
                capL       <= sensorMv;
                capHave[0] <= 1'b1;
            end
            if (captureRight) begin
                capR       <= sensorMv;
                capHave[1] <= 1'b1;
            end
            if (captureNeutral) begin
                capN       <= sensorMv;
                capHave[2] <= 1'b1;
            end
        end
    end

    assign spanR = $signed({16'h0000, capR}) - $signed({16'h0000, capN});
    assign spanL = $signed({16'h0000, capN}) - $signed({16'h0000, capL});
    assign diffS = $signed({16'h0000, sensorMv}) - $signed({16'h0000, capN});
    assign spreadUp = spanR >= $signed({16'h0000, capture_min_spread_mv})
                      && spanL >= $signed({16'h0000, capture_min_spread_mv});
    assign spreadDown = -spanR >= $signed({16'h0000, capture_min_spread_mv})
                        && -spanL >= $signed({16'h0000, capture_min_spread_mv});

    always_comb begin
        // Half-range chosen by the side the reading lies on
        spanUse = ((diffS >= 0) == (spanR >= 0)) ? spanR : spanL;
        if (spanUse == 0) scaled = 32'sd0;
        else scaled = (diffS * `CBMS_FULL_SCALE) / spanUse;
        if (scaled > `CBMS_FULL_SCALE) scaled = `CBMS_FULL_SCALE;
        if (scaled < -`CBMS_FULL_SCALE) scaled = -`CBMS_FULL_SCALE;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            calDone          <= 1'b0;
            errNeutral       <= 1'b0;
            errSpread        <= 1'b0;
            positionPermille <= 16'sh0000;
        end else begin
            calDone    <= capEnable && (&capHave);
            errNeutral <= capHave[2] && !(capN > neutral_capture_lower_mv
                          && capN < neutral_capture_upper_mv);
            errSpread  <= (&capHave) && !(spreadUp || spreadDown);
            if (capEnable && (&capHave))
                positionPermille <= scaled[15:0];
        end
    end

    // ==========================================================
    // Spool sweep sequencer
    logic [31:0] tickCnt;
    logic [7:0]  secCnt;
    logic        spoolEnable;
    logic        sweeping;
    logic [15:0] edgeMag;

    assign spoolEnable = bootDone && bootMode == MODE_SPOOL_CAL;
    assign edgeMag = measuredEdge[15] ? 16'(-measuredEdge) : measuredEdge;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            spoolState    <= SP_IDLE;
            tickCnt       <= 32'h0;
            secCnt        <= 8'h00;
            spoolSetpoint <= 16'h0000;
            errTimeout    <= 1'b0;
        end else begin
            unique case (spoolState)
                SP_IDLE: if (spoolEnable && motionStopped) begin
                    spoolState <= SP_ARMED;
                    tickCnt    <= 32'h0;
                    secCnt     <= 8'h00;
                    errTimeout <= 1'b0;
                end
                SP_ARMED: if (startRequest) begin
                    spoolState    <= SP_SWEEP;
                    spoolSetpoint <= spool_cal_initial_setpoint;
                end else if (tickCnt == 32'(TICK_CYCLES - 1)) begin
                    tickCnt <= 32'h0;
                    if (secCnt == spool_cal_start_timeout - 8'h01) begin
                        spoolState <= SP_IDLE;
                        errTimeout <= 1'b1;
                    end else begin
                        secCnt <= secCnt + 8'h01;
                    end
                end else begin
                    tickCnt <= tickCnt + 32'h1;
                end
                SP_SWEEP: if (sweepEnd && sweeping) begin
                    spoolState    <= SP_DONE;
                    spoolSetpoint <= 16'h0000;
                end
                SP_DONE: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sweeping     <= 1'b0;
            sweepCycles  <= 32'h0;
            deadbandEdge <= 16'sh0000;
            errDeadband  <= 1'b0;
        end else if (spoolState == SP_SWEEP) begin
            if (sweepBegin && !sweeping) begin
                sweeping    <= 1'b1;
                sweepCycles <= 32'h0;
            end else if (sweepEnd && sweeping) begin
                sweeping     <= 1'b0;
                deadbandEdge <= measuredEdge;
                errDeadband  <= edgeMag < deadband_edge_lower
                                || edgeMag > deadband_edge_upper;
            end else if (sweeping) begin
                sweepCycles <= sweepCycles + 32'h1;
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cbmsCk @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_boot_once;
        bootDone |=> $stable(bootMode) && bootDone;
    endproperty
    a_boot_once: assert property (p_boot_once) else $error("mode changed");
    property p_angle;
        !bootDone && (condA1 || condB1) |=> bootMode == MODE_ANGLE_CAL;
    endproperty
    a_angle: assert property (p_angle) else $error("angle cal missed");
    property p_angle_can;
        !bootDone && isCan && can_angle_cal_counter == 8'h00
        && can_angle_cal_counter_inv == 8'hFF |=> bootMode == MODE_ANGLE_CAL;
    endproperty
    a_angle_can: assert property (p_angle_can) else $error("CAN cal missed");
    property p_joy;
        !bootDone && !condA1 && !condB1 && (isCan || isNone)
        && joystick_cal_counter == 8'h00 && joystick_cal_counter_inv == 8'hFF
        |=> bootMode == MODE_JOY_CAL;
    endproperty
    a_joy: assert property (p_joy) else $error("joystick cal missed");
    property p_joy_none;
        !bootDone && sensor_interface_type == 8'h02 |=> bootMode != MODE_SPOOL_CAL
        && bootMode != MODE_ANGLE_CAL;
    endproperty
    a_joy_none: assert property (p_joy_none) else $error("bad mode for none");
    property p_spool;
        bootDone && bootMode == MODE_SPOOL_CAL |-> sensor_interface_type <= 8'h01;
    endproperty
    a_spool: assert property (p_spool) else $error("spool without sensor");
    property p_normal;
        !bootDone && !condA1 && !condB1 && !condA2 && !condB2 && !cond3
        |=> bootMode == MODE_NORMAL;
    endproperty
    a_normal: assert property (p_normal) else $error("normal missed");
    property p_neutral;
        capHave[2] && $stable(capN) && capN >= neutral_capture_upper_mv
        |=> errNeutral;
    endproperty
    a_neutral: assert property (p_neutral) else $error("neutral error missing");
    property p_setpoint;
        spoolState == SP_ARMED && startRequest
        |=> spoolSetpoint == $past(spool_cal_initial_setpoint);
    endproperty
    a_setpoint: assert property (p_setpoint) else $error("setpoint wrong");
    property p_db_range;
        $rose(spoolState == SP_DONE) && !errDeadband
        |-> (deadbandEdge[15] ? 16'(-deadbandEdge) : deadbandEdge) <= deadband_edge_upper;
    endproperty
    a_db_range: assert property (p_db_range) else $error("edge out of range");
    property p_refuse;
        paramWrEn && paramSel == 3'h0 && paramWrData > 16'h1388
        |=> $stable(neutral_capture_upper_mv);
    endproperty
    a_refuse: assert property (p_refuse) else $error("limit accepted");
    c_angle: cover property (bootDone && bootMode == MODE_ANGLE_CAL && calDone);
    c_spool_done: cover property (spoolState == SP_DONE);
    c_timeout: cover property ($rose(errTimeout));
endmodule : cbms_boot_mode_select
`default_nettype wire

// *** inc/cbms_defs.svh ***
// Purpose: constants of the boot mode selector
// Assumes: 200 MHz reference clock
// Notes:   parameter selectors are local numbering
`ifndef CBMS_DEFS_SVH
`define CBMS_DEFS_SVH
`define CBMS_IF_ANALOG      8'h00
`define CBMS_IF_CAN         8'h01
`define CBMS_IF_NONE        8'h02
`define CBMS_CNT_ZERO       8'h00
`define CBMS_CNT_INV        8'hFF
`define CBMS_SEL_NEU_UP     3'h0
`define CBMS_SEL_SPREAD     3'h1
`define CBMS_SEL_NEU_LO     3'h2
`define CBMS_SEL_DB_UP      3'h3
`define CBMS_SEL_DB_LO      3'h4
`define CBMS_SEL_TIMEOUT    3'h5
`define CBMS_SEL_SETPT      3'h6
`define CBMS_RST_NEU_UP     16'h1194
`define CBMS_RST_SPREAD     16'h0000
`define CBMS_RST_NEU_LO     16'h01F4
`define CBMS_RST_DB_UP      16'h012C
`define CBMS_RST_DB_LO      16'h0000
`define CBMS_RST_TIMEOUT    8'h14
`define CBMS_RST_SETPT      16'h007D
`define CBMS_MAX_MV         16'h1388
`define CBMS_MAX_SPREAD     16'h09C4
`define CBMS_MAX_DB         16'h012C
`define CBMS_MIN_TIMEOUT    8'h01
`define CBMS_MAX_TIMEOUT    8'h3C
`define CBMS_MIN_SETPT      16'h0032
`define CBMS_MAX_SETPT      16'h012C
`define CBMS_FULL_SCALE     1000
`define CBMS_SECOND_NS      1000000000
`define CBMS_CLK_NS         5
`endif

// *** inc/cbms_pkg.sv ***
// Purpose: types of the boot mode selector
// Assumes: nothing
// Notes:   one-hot codes
`default_nettype none
package cbms_pkg;
    typedef enum logic [3:0] {
        MODE_ANGLE_CAL = 4'h1,
        MODE_JOY_CAL   = 4'h2,
        MODE_SPOOL_CAL = 4'h4,
        MODE_NORMAL    = 4'h8
    } cbms_mode_t;
    typedef enum logic [3:0] {
        SP_IDLE  = 4'h1,
        SP_ARMED = 4'h2,
        SP_SWEEP = 4'h4,
        SP_DONE  = 4'h8
    } cbms_spool_t;
endpackage : cbms_pkg
`default_nettype wire

// *** test/cbms_operator_model.sv ***
// Purpose: sensors and operator around the boot mode selector
// Assumes: bench clock, outputs move 1 ns after the rising edge
// Notes:   start delay and measured edge set by the bench
`default_nettype none
module cbms_operator_model
    import cbms_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               runCap,
    input  wire logic               runSpool,
    input  wire logic [47:0]        pts,
    input  wire logic [1:0]         livePos,
    input  wire logic [7:0]         startWait,
    input  wire logic signed [15:0] edgeVal,
    output logic [15:0]             sensorMv,
    output logic [2:0]              capLRN,
    output logic [3:0]              spoolPulse,
    output logic signed [15:0]      measuredEdge
);
    timeunit 1ns;
    timeprecision 100ps;
    int         k;
    logic [1:0] cur = 2'h3;
    initial begin
        capLRN = 3'h0;
        spoolPulse = 4'h0;
        measuredEdge = 16'sh0000;
    end
    task automatic tick();
        @(posedge ref_clk) #1;
    endtask : tick
    assign sensorMv = pts[16 * int'(cur == 2'h3 ? livePos : cur) +: 16];
    // ==========
    // Left, right, neutral points
    always @(posedge runCap) begin
        for (k = 0; k < 3; k++) begin
            tick();
            cur = 2'(k);
            capLRN = 3'h4 >> k;
        end
        tick();
        cur = 2'h3;
        capLRN = 3'h0;
    end
    // Rest, start after a delay, timed sweep
    always @(posedge runSpool) begin
        tick();
        spoolPulse = 4'h8;
        tick();
        if (startWait != 8'h00) begin
            spoolPulse = 4'h0;
            repeat (startWait) tick();
        end
        spoolPulse = 4'h4;
        tick();
        spoolPulse = 4'h0;
        tick();
        spoolPulse = 4'h2;
        tick();
        spoolPulse = 4'h0;
        repeat (6) tick();
        spoolPulse = 4'h1;
        measuredEdge = edgeVal;
        tick();
        spoolPulse = 4'h0;
        measuredEdge = ~edgeVal;
    end
endmodule : cbms_operator_model
`default_nettype wire

// *** test/cbms_boot_mode_select_test.sv ***
// Purpose: self-checking bench of the boot mode selector
// Assumes: short tick parameter for the start timeout
// Notes:   random stimulus from a fixed seed
`default_nettype none
module cbms_boot_mode_select_test
    import cbms_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] DEF [7] = '{16'h1194, 16'h0000, 16'h01F4, 16'h012C, 16'h0000,
        16'h0014, 16'h007D};
    localparam logic [15:0] MAXV [7] = '{16'h1388, 16'h09C4, 16'h1388, 16'h012C, 16'h012C,
        16'h003C, 16'h012C};
    localparam logic [47:0] CP [5] = '{48'h09C4_0FA0_03E8, 48'h01F4_0FA0_0064,
        48'h1194_1388_03E8, 48'h09C4_0FA0_03E8, 48'h09C4_03E8_0FA0};
    localparam logic [15:0] CS [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h07D0, 16'h05DC};
    localparam logic [1:0] CE [5] = '{2'h0, 2'h2, 2'h2, 2'h1, 2'h0};
    localparam logic signed [15:0] PP [3] = '{16'hFC18, 16'h03E8, 16'h0000};
    localparam logic signed [15:0] SE [5] = '{16'h00C8, 16'hFEA2, 16'hFFFB, 16'h012C, 16'h0000};
    localparam logic [15:0] SL [5] = '{16'h0000, 16'h0000, 16'h000A, 16'h0000, 16'h0000};
    localparam logic [7:0] SW [5] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h14};
    localparam logic [15:0] ST [5] = '{16'h0014, 16'h0014, 16'h0014, 16'h0014, 16'h0001};
    localparam logic [1:0] SX [5] = '{2'h0, 2'h2, 2'h2, 2'h0, 2'h1};
    logic ref_clk = 1'b0, rst = 1'b1, paramWrEn = 1'b0, runCap = 1'b0, runSpool = 1'b0;
    logic [7:0] typ = 8'h00, startWait = 8'h00;
    logic [15:0] pr [4] = '{default: 16'h0101};
    logic [2:0] paramSel = 3'h0, capLRN;
    logic [15:0] paramWrData = 16'h0000, sensorMv, paramRdData, spoolSetpoint, sp;
    logic [47:0] pts = 48'h0;
    logic [1:0] livePos = 2'h2;
    logic signed [15:0] edgeVal = 16'sh0000, measuredEdge, positionPermille, deadbandEdge;
    logic [3:0] spoolPulse;
    logic paramWrRefused, bootDone, calDone, errNeutral, errSpread, errDeadband, errTimeout;
    logic [31:0] sweepCycles;
    cbms_mode_t bootMode, em;
    cbms_spool_t spoolState;
    int nFail = 0, checksDone = 0, i, k, n;
    integer seed = 8063;
    cbms_boot_mode_select #(.TICK_CYCLES(4)) dut (
        .sensor_interface_type(typ), .captureLeft(capLRN[2]), .captureRight(capLRN[1]),
        .analog_angle_cal_counter(pr[0][15:8]), .analog_angle_cal_counter_inv(pr[0][7:0]),
        .can_angle_cal_counter(pr[1][15:8]), .can_angle_cal_counter_inv(pr[1][7:0]),
        .joystick_cal_counter(pr[2][15:8]), .joystick_cal_counter_inv(pr[2][7:0]),
        .spool_cal_counter(pr[3][15:8]), .spool_cal_counter_inv(pr[3][7:0]),
        .captureNeutral(capLRN[0]), .motionStopped(spoolPulse[3]),
        .startRequest(spoolPulse[2]), .sweepBegin(spoolPulse[1]), .sweepEnd(spoolPulse[0]),
        .*
    );
    cbms_operator_model partner (.*);
    always #2.5 ref_clk = ~ref_clk;
    // ==========
    // Tasks
    task automatic tick();
        @(posedge ref_clk) #1;
    endtask : tick
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string w);
        checksDone++;
        if (g !== e) begin
            nFail++;
            $display("unexpected at %0t ns: %s got %0h expected %0h", $time, w, g, e);
        end
    endtask : chk
    task automatic closeOut();
        $display("checks %0d, mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : closeOut
    task automatic boot(input int c, input logic [7:0] t);
        rst = 1'b1;
        typ = t;
        repeat (c) tick();
        rst = 1'b0;
        tick();
    endtask : boot
    task automatic wr(input logic [2:0] s, input logic [15:0] d, input logic bad);
        paramWrEn = 1'b1;
        paramSel = s;
        paramWrData = d;
        #1 chk(paramWrRefused, bad, "refused");
        tick();
        paramWrEn = 1'b0;
        tick();
    endtask : wr
    task automatic rd(input logic [2:0] s, input logic [15:0] e);
        paramSel = s;
        tick();
        chk(paramRdData, e, "read");
    endtask : rd
    function automatic cbms_mode_t expMode(input logic [7:0] t, input logic [15:0] p [4]);
        if ((t == 8'h00 && p[0] == 16'h00FF) || (t == 8'h01 && p[1] == 16'h00FF))
            return MODE_ANGLE_CAL;
        if ((t == 8'h01 || t == 8'h02) && p[2] == 16'h00FF) return MODE_JOY_CAL;
        if (t < 8'h02 && p[3] == 16'h00FF) return MODE_SPOOL_CAL;
        return MODE_NORMAL;
    endfunction : expMode
    // ==========
    // Main sequence
    initial begin
        for (i = 0; i < 64; i++) begin
            for (k = 0; k < 4; k++)
                pr[k] = (i < 48 && ((i / 3) >> k) % 2 == 1) ? 16'h00FF : 16'($random(seed));
            boot(i == 0 ? 20 : 2, i < 48 ? 8'(i % 3) : 8'($unsigned($random(seed)) % 3));
            em = expMode(typ, pr);
            chk(bootDone, 1'b1, "boot done");
            chk(bootMode, em, "boot mode");
            for (k = 0; k < 4; k++) pr[k] = ~pr[k];
            typ = typ ^ 8'h01;
            repeat (3) tick();
            chk(bootMode, em, "held mode");
        end
        pr = '{default: 16'h0101};
        boot(2, 8'h00);
        for (k = 0; k < 7; k++) begin
            rd(3'(k), DEF[k]);
            wr(3'(k), MAXV[k] + 16'h0001, 1'b1);
            wr(3'(k), MAXV[k], 1'b0);
            rd(3'(k), MAXV[k]);
        end
        wr(3'h5, 16'h0000, 1'b1);
        wr(3'h6, 16'h0031, 1'b1);
        for (i = 0; i < 5; i++) begin
            pr = '{default: 16'h0101};
            pr[i < 4 ? 0 : 2] = 16'h00FF;
            boot(2, i < 4 ? 8'h00 : 8'h02);
            wr(3'h1, CS[i], 1'b0);
            pts = CP[i];
            livePos = 2'h2;
            runCap = 1'b1;
            tick();
            runCap = 1'b0;
            repeat (12) tick();
            chk({errNeutral, errSpread}, CE[i], "capture flags");
            if (CE[i] == 2'h0) begin
                chk(calDone, 1'b1, "cal done");
                for (k = 0; k < 3; k++) begin
                    livePos = 2'(k);
                    repeat (2) tick();
                    chk(positionPermille, PP[k], "position");
                end
            end
        end
        for (i = 0; i < 5; i++) begin
            pr = '{default: 16'h0101};
            pr[3] = 16'h00FF;
            boot(2, 8'h01);
            sp = 16'h0032 + 16'($unsigned($random(seed)) % 251);
            wr(3'h6, sp, 1'b0);
            wr(3'h4, SL[i], 1'b0);
            wr(3'h5, ST[i], 1'b0);
            edgeVal = SE[i];
            startWait = SW[i];
            runSpool = 1'b1;
            tick();
            runSpool = 1'b0;
            for (n = 0; n < 200 && spoolState !== SP_DONE && errTimeout !== 1'b1; n++) begin
                tick();
                if (spoolState === SP_SWEEP) chk(spoolSetpoint, sp, "setpoint");
            end
            tick();
            chk({errDeadband, errTimeout}, SX[i], "spool flags");
            if (SX[i] == 2'h1) begin
                chk(spoolState, SP_IDLE, "timed out");
            end else begin
                chk(deadbandEdge, SE[i], "edge");
                chk(sweepCycles, 32'h6, "sweep");
            end
        end
        closeOut();
    end
    initial begin
        repeat (30000) @(posedge ref_clk);
        nFail++;
        closeOut();
    end
endmodule : cbms_boot_mode_select_test
`default_nettype wire
